/* File: verilog/cvc_pkg.sv */
package cvc_pkg;

    // ========================================================
    // Register map
    localparam logic [7:0] ADDR_LUMA_GAIN = 8'h03;
    localparam logic [7:0] ADDR_SCALER_SELECT = 8'h04;
    localparam logic [7:0] ADDR_FEATURE_ENABLES = 8'h05;
    localparam logic [7:0] ADDR_LINE_PHASE_REF = 8'h06;
    localparam logic [7:0] ADDR_OPERATION_EXTRA = 8'h07;
    localparam logic [7:0] ADDR_RED_WEIGHT = 8'h08;
    localparam logic [7:0] ADDR_BLUE_WEIGHT = 8'h09;

    // ========================================================
    // Writable bit masks
    localparam logic [7:0] MASK_LUMA_GAIN = 8'h1f;
    localparam logic [7:0] MASK_SCALER_SELECT = 8'h0f;
    localparam logic [7:0] MASK_FEATURE_ENABLES = 8'h1c;
    localparam logic [7:0] MASK_LINE_PHASE_REF = 8'h1f;
    localparam logic [7:0] MASK_OPERATION_EXTRA = 8'hc0;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_NONE = 8'h00;

    // ========================================================
    // Reset values
    localparam logic [7:0] RST_LUMA_GAIN = 8'h08;
    localparam logic [7:0] RST_SCALER_SELECT = 8'h00;
    localparam logic [7:0] RST_FEATURE_ENABLES = 8'h00;
    localparam logic [7:0] RST_LINE_PHASE_REF = 8'h0d;
    localparam logic [7:0] RST_OPERATION_EXTRA = 8'h00;
    localparam logic [7:0] RST_RED_WEIGHT = 8'h80;
    localparam logic [7:0] RST_BLUE_WEIGHT = 8'h80;

    // ========================================================
    // Field positions
    localparam int SCALER_CUSTOM_BIT = 3;
    localparam int FEAT_AWB_BIT = 1;
    localparam int FEAT_GAMMA_BIT = 2;
    localparam int FEAT_PEAK_OFF_BIT = 3;
    localparam int FEAT_CHROMA_OFF_BIT = 4;
    localparam int OPC_ODD_BLUE_BIT = 0;
    localparam int OPC_EVEN_BLUE_BIT = 1;
    localparam int OPC_POS_PIXEL_BIT = 2;
    localparam int OPC_OE_BIT = 3;
    localparam int OPC_REF_PIN_BIT = 4;
    localparam int OP2_CLIPPING_DISABLE_BIT = 6;
    localparam int OP2_TEST_BIT = 7;

    // ========================================================
    // Datapath and white balance constants
    localparam int GAIN_SHIFT = 3;
    localparam int WEIGHT_SHIFT = 8;
    localparam logic [7:0] VIDEO_MAX = 8'hff;
    localparam logic [7:0] WEIGHT_MIN = 8'h00;
    localparam logic [7:0] WEIGHT_MAX = 8'hff;
    localparam logic signed [7:0] AWB_TOL = 8'sh02;
    localparam logic [7:0] AWB_MAX_STEPS = 8'hff;
    localparam logic [7:0] ZERO8 = 8'h00;

    typedef enum logic {CVC_AWB_IDLE, CVC_AWB_RUN} cvc_awb_e;

    typedef struct packed {
        logic red_up;
        logic red_dn;
        logic blue_up;
        logic blue_dn;
    } cvc_step_s;

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] red_w;
        logic [7:0] blue_w;
    } cvc_weights_s;

endpackage

/* File: verilog/cvc_awb_engine.sv */
`timescale 1ns/1ps
module cvc_awb_engine
    import cvc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic sample_i,
    input wire logic signed [7:0] ry_i,
    input wire logic signed [7:0] by_i,
    output logic busy_o,
    output cvc_step_s step_o
);

    typedef struct packed {
        cvc_awb_e mode;
        logic [7:0] steps;
        cvc_step_s step;
    } cvc_awb_state_s;

    cvc_awb_state_s s_q, s_d;
    logic ry_ok, by_ok;

    assign ry_ok = (ry_i <= AWB_TOL) && (ry_i >= -AWB_TOL);
    assign by_ok = (by_i <= AWB_TOL) && (by_i >= -AWB_TOL);

    // ========================================================
    // Balance search
    always_comb begin
        s_d = s_q;
        s_d.step = '0;
        case (s_q.mode)
            CVC_AWB_IDLE: begin
                if (start_i) begin
                    s_d.mode = CVC_AWB_RUN;
                    s_d.steps = ZERO8;
                end
            end
            CVC_AWB_RUN: begin
                if (sample_i) begin
                    if ((ry_ok && by_ok) || s_q.steps == AWB_MAX_STEPS) begin
                        s_d.mode = CVC_AWB_IDLE;
                    end else begin
                        s_d.steps = s_q.steps + 8'h01;
                        s_d.step.red_dn = ry_i > AWB_TOL;
                        s_d.step.red_up = ry_i < -AWB_TOL;
                        s_d.step.blue_dn = by_i > AWB_TOL;
                        s_d.step.blue_up = by_i < -AWB_TOL;
                    end
                end
            end
            default: s_d.mode = CVC_AWB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{CVC_AWB_IDLE, ZERO8, 4'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = (s_q.mode == CVC_AWB_RUN);
    assign step_o = s_q.step;

    // ========================================================
    // Checks
    property p_awb_red_step;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.mode == CVC_AWB_RUN && sample_i && ry_i > AWB_TOL
            && s_q.steps != AWB_MAX_STEPS)
        |=> step_o.red_dn && !step_o.red_up;
    endproperty
    a_awb_red_step: assert property (p_awb_red_step)
        else $error("red weight not lowered for positive R-Y");

    property p_awb_blue_step;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.mode == CVC_AWB_RUN && sample_i && by_i < -AWB_TOL
            && s_q.steps != AWB_MAX_STEPS)
        |=> step_o.blue_up && !step_o.blue_dn;
    endproperty
    a_awb_blue_step: assert property (p_awb_blue_step)
        else $error("blue weight not raised for negative B-Y");

endmodule

/* File: verilog/cvc_video_path.sv */
`timescale 1ns/1ps
module cvc_video_path
    import cvc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cvc_weights_s w_i,
    input wire logic [7:0] luma_i,
    input wire logic [7:0] red_i,
    input wire logic [7:0] blue_i,
    output logic [7:0] luma_o,
    output logic [7:0] red_o,
    output logic [7:0] blue_o
);

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] red;
        logic [7:0] blue;
    } cvc_vid_state_s;

    cvc_vid_state_s s_q, s_d;
    logic [12:0] luma_prod;
    logic [9:0] luma_scaled;
    logic [16:0] red_prod, blue_prod;

    // Weight plus one so that FFh passes the colour at full scale
    function automatic logic [7:0] cvc_weigh(input logic [16:0] p);
        cvc_weigh = p[WEIGHT_SHIFT +: 8];
    endfunction

    // ========================================================
    // Gain and weighting
    always_comb begin
        luma_prod = luma_i * w_i.gain[4:0];
        luma_scaled = luma_prod[GAIN_SHIFT +: 10];
        red_prod = red_i * ({1'b0, w_i.red_w} + 9'h001);
        blue_prod = blue_i * ({1'b0, w_i.blue_w} + 9'h001);
        s_d.luma = (luma_scaled > {2'h0, VIDEO_MAX}) ? VIDEO_MAX
                                                     : luma_scaled[7:0];
        s_d.red = cvc_weigh(red_prod);
        s_d.blue = cvc_weigh(blue_prod);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign luma_o = s_q.luma;
    assign red_o = s_q.red;
    assign blue_o = s_q.blue;

    // ========================================================
    // Checks
    property p_zero_gain;
        @(posedge clk_i) disable iff (rst_i)
        (w_i.gain[4:0] == 5'h00) |=> (luma_o == ZERO8);
    endproperty
    a_zero_gain: assert property (p_zero_gain)
        else $error("luma not dark at zero gain");

    property p_unity_gain;
        @(posedge clk_i) disable iff (rst_i)
        (w_i.gain[4:0] == 5'h08) |=> (luma_o == $past(luma_i));
    endproperty
    a_unity_gain: assert property (p_unity_gain)
        else $error("gain of eight eighths altered luma");

endmodule

/* File: verilog/cvc_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Luma out equals luma in times five-bit gain over eight.
// - Gain of zero gives fully dark luma.
// - Three-bit field picks one of eight fixed scaler ratios.
// - Custom bit makes scaler use custom coefficient registers instead.
// - Trigger bit reads one while white balance runs, else zero.
// - Writing zero to the trigger bit changes nothing.
// - Gamma bit routes RGB through a 256-entry lookup table.
// - Peaking disable bit bypasses the luma peaking filter.
// - Chroma disable bit bypasses the chroma low-pass filter.
// - Odd field first line is blue when its bit is one.
// - Even field first line is blue when its bit is one.
// - Pixel bit one makes first pixel positive, zero negative.
// - Video outputs drive only when enable bit and pin both high.
// - Reference bit one times lines and fields from the pins.
// - Reference bit zero follows embedded EAV and SAV codes.
// - Test bit value, one or zero, does not disturb operation.
// - Red weight scales red into R-Y, monotonic 00h to FFh.
// - White balance adjusts red weight to minimise R-Y magnitude.
// - Blue weight scales blue into B-Y, monotonic 00h to FFh.
// - White balance adjusts blue weight to minimise B-Y magnitude.
module cvc_regs
    import cvc_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic TRISTATE_CONTROL_PIN_I,
    input wire logic HORIZONTAL_REFERENCE_PIN_I,
    input wire logic VERTICAL_REFERENCE_PIN_I,
    input wire logic EMB_LINE_START_I,
    input wire logic EMB_FIELD_START_I,
    input wire logic FIELD_EVEN_I,
    input wire logic [7:0] SVIDEO_LUMA_I,
    input wire logic [7:0] RED_I,
    input wire logic [7:0] BLUE_I,
    input wire logic CDIFF_VALID_I,
    input wire logic signed [7:0] RY_I,
    input wire logic signed [7:0] BY_I,
    output logic [7:0] REG_RDATA_O,
    output logic [2:0] SCALER_RATIO_O,
    output logic SCALER_CUSTOM_O,
    output logic GAMMA_ENABLE_O,
    output logic PEAKING_DISABLE_O,
    output logic CHROMA_FILTER_DISABLE_O,
    output logic FIRST_LINE_BLUE_O,
    output logic FIRST_PIXEL_POLARITY_O,
    output logic CLIPPING_DISABLE_O,
    output logic VIDEO_DRIVE_O,
    output logic LINE_SYNC_O,
    output logic FIELD_SYNC_O,
    output logic AWB_BUSY_O,
    output logic [7:0] SVIDEO_LUMA_O,
    output logic [7:0] RED_CONTRIB_O,
    output logic [7:0] BLUE_CONTRIB_O
);

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] scaler;
        logic [7:0] feat;
        logic [7:0] opc;
        logic [7:0] op2;
        logic [7:0] red_w;
        logic [7:0] blue_w;
        logic [7:0] rdata;
        logic [1:0] tri_sync;
        logic [1:0] horizontal_reference_pin_sync;
        logic [1:0] vref_sync;
        logic horizontal_reference_pin_prev;
        logic vref_prev;
        logic drive;
        logic line_sync;
        logic field_sync;
        logic first_blue;
        logic awb_busy;
    } cvc_top_state_s;

    cvc_top_state_s s_q, s_d;
    logic awb_busy, awb_start;
    cvc_step_s awb_step;
    cvc_weights_s weights;

    // ========================================================
    // Address decode
    function automatic logic [7:0] cvc_wmask(input logic [7:0] a);
        case (a)
            ADDR_LUMA_GAIN: cvc_wmask = MASK_LUMA_GAIN;
            ADDR_SCALER_SELECT: cvc_wmask = MASK_SCALER_SELECT;
            ADDR_FEATURE_ENABLES: cvc_wmask = MASK_FEATURE_ENABLES;
            ADDR_LINE_PHASE_REF: cvc_wmask = MASK_LINE_PHASE_REF;
            ADDR_OPERATION_EXTRA: cvc_wmask = MASK_OPERATION_EXTRA;
            ADDR_RED_WEIGHT: cvc_wmask = MASK_FULL;
            ADDR_BLUE_WEIGHT: cvc_wmask = MASK_FULL;
            default: cvc_wmask = MASK_NONE;
        endcase
    endfunction

    function automatic logic [7:0] cvc_step_weight(input logic [7:0] w,
                                                   input logic up,
                                                   input logic dn);
        if (up && w != WEIGHT_MAX) begin
            cvc_step_weight = w + 8'h01;
        end else if (dn && w != WEIGHT_MIN) begin
            cvc_step_weight = w - 8'h01;
        end else begin
            cvc_step_weight = w;
        end
    endfunction

    assign awb_start = REG_WR_I && REG_ADDR_I == ADDR_FEATURE_ENABLES
                       && REG_WDATA_I[FEAT_AWB_BIT] && !awb_busy;

    cvc_awb_engine u_awb (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .start_i(awb_start),
        .sample_i(CDIFF_VALID_I),
        .ry_i(RY_I),
        .by_i(BY_I),
        .busy_o(awb_busy),
        .step_o(awb_step)
    );

    assign weights = '{s_q.gain, s_q.red_w, s_q.blue_w};

    cvc_video_path u_video (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .w_i(weights),
        .luma_i(SVIDEO_LUMA_I),
        .red_i(RED_I),
        .blue_i(BLUE_I),
        .luma_o(SVIDEO_LUMA_O),
        .red_o(RED_CONTRIB_O),
        .blue_o(BLUE_CONTRIB_O)
    );

    // ========================================================
    // Register file and control
    always_comb begin
        logic [7:0] wv;
        wv = REG_WDATA_I & cvc_wmask(REG_ADDR_I);
        s_d = s_q;
        // Pins pass two flops before use
        s_d.tri_sync = {s_q.tri_sync[0], TRISTATE_CONTROL_PIN_I};
        s_d.horizontal_reference_pin_sync = {s_q.horizontal_reference_pin_sync[0], HORIZONTAL_REFERENCE_PIN_I};
        s_d.vref_sync = {s_q.vref_sync[0], VERTICAL_REFERENCE_PIN_I};
        s_d.horizontal_reference_pin_prev = s_q.horizontal_reference_pin_sync[1];
        s_d.vref_prev = s_q.vref_sync[1];
        s_d.awb_busy = awb_busy;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                ADDR_LUMA_GAIN: s_d.gain = wv;
                ADDR_SCALER_SELECT: s_d.scaler = wv;
                ADDR_FEATURE_ENABLES: s_d.feat = wv;
                ADDR_LINE_PHASE_REF: s_d.opc = wv;
                ADDR_OPERATION_EXTRA: s_d.op2 = wv;
                default: s_d.gain = s_q.gain;
            endcase
            // Engine owns the weights while balancing
            if (!awb_busy && REG_ADDR_I == ADDR_RED_WEIGHT) begin
                s_d.red_w = wv;
            end
            if (!awb_busy && REG_ADDR_I == ADDR_BLUE_WEIGHT) begin
                s_d.blue_w = wv;
            end
        end
        s_d.red_w = cvc_step_weight(s_d.red_w, awb_step.red_up,
                                    awb_step.red_dn);
        s_d.blue_w = cvc_step_weight(s_d.blue_w, awb_step.blue_up,
                                     awb_step.blue_dn);
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                ADDR_LUMA_GAIN: s_d.rdata = s_q.gain;
                ADDR_SCALER_SELECT: s_d.rdata = s_q.scaler;
                ADDR_FEATURE_ENABLES: begin
                    s_d.rdata = s_q.feat;
                    s_d.rdata[FEAT_AWB_BIT] = awb_busy;
                end
                ADDR_LINE_PHASE_REF: s_d.rdata = s_q.opc;
                ADDR_OPERATION_EXTRA: s_d.rdata = s_q.op2;
                ADDR_RED_WEIGHT: s_d.rdata = s_q.red_w;
                ADDR_BLUE_WEIGHT: s_d.rdata = s_q.blue_w;
                default: s_d.rdata = ZERO8;
            endcase
        end
        s_d.drive = s_q.opc[OPC_OE_BIT] && s_q.tri_sync[1];
        if (s_q.opc[OPC_REF_PIN_BIT]) begin
            s_d.line_sync = s_q.horizontal_reference_pin_sync[1] && !s_q.horizontal_reference_pin_prev;
            s_d.field_sync = s_q.vref_sync[1] && !s_q.vref_prev;
        end else begin
            s_d.line_sync = EMB_LINE_START_I;
            s_d.field_sync = EMB_FIELD_START_I;
        end
        s_d.first_blue = FIELD_EVEN_I ? s_q.opc[OPC_EVEN_BLUE_BIT]
                                      : s_q.opc[OPC_ODD_BLUE_BIT];
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            s_q <= '0;
            s_q.gain <= RST_LUMA_GAIN;
            s_q.scaler <= RST_SCALER_SELECT;
            s_q.feat <= RST_FEATURE_ENABLES;
            s_q.opc <= RST_LINE_PHASE_REF;
            s_q.op2 <= RST_OPERATION_EXTRA;
            s_q.red_w <= RST_RED_WEIGHT;
            s_q.blue_w <= RST_BLUE_WEIGHT;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs
    assign REG_RDATA_O = s_q.rdata;
    assign SCALER_RATIO_O = s_q.scaler[2:0];
    assign SCALER_CUSTOM_O = s_q.scaler[SCALER_CUSTOM_BIT];
    assign GAMMA_ENABLE_O = s_q.feat[FEAT_GAMMA_BIT];
    assign PEAKING_DISABLE_O = s_q.feat[FEAT_PEAK_OFF_BIT];
    assign CHROMA_FILTER_DISABLE_O = s_q.feat[FEAT_CHROMA_OFF_BIT];
    assign FIRST_PIXEL_POLARITY_O = s_q.opc[OPC_POS_PIXEL_BIT];
    assign CLIPPING_DISABLE_O = s_q.op2[OP2_CLIPPING_DISABLE_BIT];
    assign FIRST_LINE_BLUE_O = s_q.first_blue;
    assign VIDEO_DRIVE_O = s_q.drive;
    assign LINE_SYNC_O = s_q.line_sync;
    assign FIELD_SYNC_O = s_q.field_sync;
    assign AWB_BUSY_O = s_q.awb_busy;

    // ========================================================
    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    sequence s_awb_request;
        REG_WR_I && REG_ADDR_I == ADDR_FEATURE_ENABLES
            && REG_WDATA_I[FEAT_AWB_BIT] && !awb_busy;
    endsequence

    sequence s_awb_reads_busy;
        REG_RD_I && REG_ADDR_I == ADDR_FEATURE_ENABLES ##1
            REG_RDATA_O[FEAT_AWB_BIT];
    endsequence

    property p_awb_start;
        s_awb_request |=> awb_busy ##1 AWB_BUSY_O;
    endproperty
    a_awb_start: assert property (p_awb_start)
        else $error("white balance did not start");

    property p_awb_read;
        (REG_RD_I && REG_ADDR_I == ADDR_FEATURE_ENABLES)
            |=> REG_RDATA_O[FEAT_AWB_BIT] == $past(awb_busy);
    endproperty
    a_awb_read: assert property (p_awb_read)
        else $error("trigger bit does not show busy state");

    property p_awb_zero_write;
        (awb_busy && !CDIFF_VALID_I && REG_WR_I
            && REG_ADDR_I == ADDR_FEATURE_ENABLES
            && !REG_WDATA_I[FEAT_AWB_BIT]) |=> awb_busy;
    endproperty
    a_awb_zero_write: assert property (p_awb_zero_write)
        else $error("zero write disturbed white balance");

    property p_gain_write;
        (REG_WR_I && REG_ADDR_I == ADDR_LUMA_GAIN)
            |=> s_q.gain == ($past(REG_WDATA_I) & MASK_LUMA_GAIN);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("gain reserved bits not cleared");

    property p_drive;
        (s_q.opc[OPC_OE_BIT] && s_q.tri_sync[1]) |=> VIDEO_DRIVE_O;
    endproperty
    a_drive: assert property (p_drive)
        else $error("video outputs not enabled");

    property p_no_drive;
        !s_q.opc[OPC_OE_BIT] |=> !VIDEO_DRIVE_O;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("video outputs driven with enable clear");

    property p_pin_timing;
        (s_q.opc[OPC_REF_PIN_BIT] && s_q.horizontal_reference_pin_sync[1] && !s_q.horizontal_reference_pin_prev)
            |=> LINE_SYNC_O;
    endproperty
    a_pin_timing: assert property (p_pin_timing)
        else $error("line not timed from reference pin");

    property p_code_timing;
        !s_q.opc[OPC_REF_PIN_BIT]
            |=> LINE_SYNC_O == $past(EMB_LINE_START_I, 1);
    endproperty
    a_code_timing: assert property (p_code_timing)
        else $error("line not timed from embedded code");

    property p_odd_phase;
        !FIELD_EVEN_I |=> FIRST_LINE_BLUE_O
            == $past(s_q.opc[OPC_ODD_BLUE_BIT]);
    endproperty
    a_odd_phase: assert property (p_odd_phase)
        else $error("odd field line phase wrong");

endmodule

/* File: verification/cvc_cd_model.sv */
`timescale 1ns/1ps
// ========================================
// Colour-difference source
module cvc_cd_model
    import cvc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] r_i,
    input wire logic [7:0] b_i,
    output logic v_o,
    output logic signed [7:0] ry_o,
    output logic signed [7:0] by_o
);
    logic [2:0] t_q;
    // Slow pace lets each step settle; stale values inverted
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            t_q <= 3'h0;
            v_o <= 1'b0;
            ry_o <= 8'sh00;
            by_o <= 8'sh00;
        end else begin
            t_q <= t_q + 3'h1;
            v_o <= t_q == 3'h7;
            ry_o <= (t_q == 3'h7) ? r_i - 8'h60 : ~ry_o;
            by_o <= (t_q == 3'h7) ? b_i - 8'ha0 : ~by_o;
        end
    end
endmodule

/* File: verification/tb_cvc_regs.sv */
`timescale 1ns/1ps
module tb_cvc_regs;
    import cvc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b0;
    logic [7:0] a = 8'h00, wd = 8'h00, y = 8'h00, col = 8'hff;
    logic [7:0] rdat, luma, rc, bc, v, g;
    logic [2:0] ratio;
    logic drive, busy, cus, cv;
    logic gam, pkd, chf, fb, pos, clo, ls, fs;
    logic horizontal_reference_pin = 1'b0, vref = 1'b0, eln = 1'b0, efs = 1'b0, fe = 1'b0;
    logic signed [7:0] ry, by;
    int failures = 0, check_count = 0, cyc = 0;
    logic [7:0] rstv [7] = '{8'h08, 8'h00, 8'h00, 8'h0d, 8'h00, 8'h80, 8'h80};
    logic [7:0] msk [7] = '{8'h1f, 8'h0f, 8'h1c, 8'h1f, 8'hc0, 8'hff, 8'hff};
    cvc_regs DUT (.CLOCK_I(clk), .RESET_I(rst), .REG_ADDR_I(a),
        .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
        .TRISTATE_CONTROL_PIN_I(pin), .HORIZONTAL_REFERENCE_PIN_I(horizontal_reference_pin),
        .VERTICAL_REFERENCE_PIN_I(vref), .EMB_LINE_START_I(eln),
        .EMB_FIELD_START_I(efs), .FIELD_EVEN_I(fe), .SVIDEO_LUMA_I(y),
        .RED_I(col), .BLUE_I(col), .CDIFF_VALID_I(cv), .RY_I(ry),
        .BY_I(by), .REG_RDATA_O(rdat), .SCALER_RATIO_O(ratio),
        .SCALER_CUSTOM_O(cus), .GAMMA_ENABLE_O(gam),
        .PEAKING_DISABLE_O(pkd),
        .CHROMA_FILTER_DISABLE_O(chf), .FIRST_LINE_BLUE_O(fb),
        .FIRST_PIXEL_POLARITY_O(pos), .CLIPPING_DISABLE_O(clo),
        .VIDEO_DRIVE_O(drive), .LINE_SYNC_O(ls), .FIELD_SYNC_O(fs),
        .AWB_BUSY_O(busy), .SVIDEO_LUMA_O(luma), .RED_CONTRIB_O(rc),
        .BLUE_CONTRIB_O(bc));
    cvc_cd_model PEER (.clk_i(clk), .rst_i(rst), .r_i(rc), .b_i(bc),
        .v_o(cv), .ry_o(ry), .by_o(by));
    initial begin
        forever #50 clk = ~clk;
    end
    // ========================================
    // Helpers
    function automatic logic [7:0] gain_f(logic [7:0] x, logic [7:0] k);
        logic [15:0] p;
        p = (16'(x) * 16'(k)) >> 3;
        return (p > 16'h00ff) ? 8'hff : p[7:0];
    endfunction
    function automatic logic [7:0] wt_f(logic [7:0] x, logic [7:0] w);
        logic [16:0] p;
        p = (17'(x) * (17'(w) + 17'h1)) >> 8;
        return p[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        a = ad;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] ad, output logic [7:0] d);
        @(negedge clk);
        a = ad;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        d = rdat;
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("[ERR] t=%0t timeout", $time);
            summarize();
        end
    end
    // ========================================
    // Tests
    initial begin
        void'($urandom(85));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 7; k++) begin
            rreg(8'h03 + 8'(k), v);
            chk(v, rstv[k]);
        end
        rreg(8'h0a, v);
        chk(v, 8'h00);
        for (int n = 0; n < 10; n++) begin
            for (int k = 0; k < 7; k++) begin
                // Trigger bit kept low so no balance run starts
                g = 8'($urandom) & 8'hfd;
                wreg(8'h03 + 8'(k), g);
                rreg(8'h03 + 8'(k), v);
                chk(v, g & msk[k]);
            end
            g = 8'($urandom);
            fe = g[5];
            wreg(8'h04, g);
            wreg(8'h05, g & 8'hfd);
            wreg(8'h06, g);
            wreg(8'h07, g);
            repeat (2) @(negedge clk);
            chk({4'h0, cus, ratio}, {4'h0, g[3:0]});
            chk({3'h0, chf, pkd, gam, 2'h0}, g & 8'h1c);
            chk({5'h0, pos, fb, clo},
                {5'h0, g[2], g[5] ? g[1] : g[0], g[6]});
        end
        $display("test regs done");
        for (int n = 0; n < 20; n++) begin
            g = (n == 0) ? 8'h00 : (n == 1) ? 8'h1f : 8'($urandom_range(31));
            y = (n == 1) ? 8'hff : 8'($urandom);
            wreg(8'h03, g);
            repeat (2) @(negedge clk);
            chk(luma, gain_f(y, g));
        end
        $display("test gain done");
        for (int n = 0; n < 10; n++) begin
            g = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : 8'($urandom);
            col = 8'($urandom);
            wreg(8'h08, g);
            wreg(8'h09, ~g);
            repeat (2) @(negedge clk);
            chk(rc, wt_f(col, g));
            chk(bc, wt_f(col, ~g));
        end
        $display("test weights done");
        for (int k = 0; k < 4; k++) begin
            wreg(8'h06, k[1] ? 8'h0d : 8'h05);
            pin = k[0];
            repeat (6) @(negedge clk);
            chk({7'h0, drive}, {7'h0, k[1] & k[0]});
        end
        $display("test drive done");
        // Pin pulse shows after sync and edge detect, code pulse next edge
        for (int k = 0; k < 2; k++) begin
            wreg(8'h06, k[0] ? 8'h10 : 8'h00);
            {horizontal_reference_pin, vref, eln, efs} = 4'hf;
            for (int n = 1; n < 5; n++) begin
                @(negedge clk);
                {horizontal_reference_pin, vref, eln, efs} = 4'h0;
                chk({6'h0, ls, fs},
                    (n == (k ? 3 : 1)) ? 8'h03 : 8'h00);
            end
        end
        $display("test sync done");
        col = 8'hff;
        wreg(8'h08, 8'h80);
        wreg(8'h09, 8'h80);
        wreg(8'h05, 8'h02);
        repeat (3) @(negedge clk);
        wreg(8'h05, 8'h00);
        rreg(8'h05, v);
        chk(v, 8'h02);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
        rreg(8'h05, v);
        chk(v, 8'h00);
        rreg(8'h08, v);
        chk({7'h0, v >= 8'h5e && v <= 8'h62}, 8'h01);
        rreg(8'h09, v);
        chk({7'h0, v >= 8'h9e && v <= 8'ha2}, 8'h01);
        $display("test balance done");
        summarize();
    end
endmodule
